//--- dv/host_and_phy_pin_function_mux_sva.sv
// Port checker for the pin function multiplexer, with its bind.
`timescale 1ns/1ps
// ==================================================================
// Checker
module host_and_phy_pin_function_mux_sva
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic writeEnOrDirN,
    input wire logic coreWriteStrobe,
    input wire pin_mux_pkg::host_mode_t hostMode,
    input wire logic [1:0] clkoutFreqSel,
    input wire logic guardTickPinOe,
    input wire logic macroPinOe,
    input wire logic armPinOe,
    input wire logic txd1PinOe,
    input wire logic [3:0] strapPulldownOn,
    input wire logic [pin_mux_pkg::DEBUG_SRC_W-1:0] debugSources,
    input wire logic [pin_mux_pkg::DEBUG_SEL_W-1:0] debugSelOne,
    input wire logic [pin_mux_pkg::DEBUG_SEL_W-1:0] debugSelTwo,
    input wire logic debug_strobe_one,
    input wire logic debug_strobe_two,
    input wire logic chanTxActive1,
    input wire logic chanTxActive2,
    input wire logic txEnablePin1N,
    input wire logic txEnablePin2N,
    input wire logic [pin_mux_pkg::INPUT_PINS-1:0] pullEnableWr,
    input wire logic [pin_mux_pkg::OUTPUT_PINS-1:0] driveFullWr,
    input wire logic padCfgWrite,
    input wire logic [pin_mux_pkg::INPUT_PINS-1:0] pullEnable,
    input wire logic [pin_mux_pkg::OUTPUT_PINS-1:0] driveFull
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence relSeq;
        $fell(sys_rst);
    endsequence
    // Writes count only once the straps chose the memory-style host.
    sequence weRiseSeq;
        txd1PinOe && hostMode == HOST_ASYNC_MEM && $rose(writeEnOrDirN);
    endsequence
    a_pads_reset: assert property (relSeq |-> pullEnable == PULL_EN_RESET
        && driveFull == DRIVE_FULL_RESET) else $error("pad reset wrong");
    a_strap_hold: assert property (relSeq |-> strapPulldownOn == 4'hF
        && !txd1PinOe && !guardTickPinOe) else $error("strap not held");
    a_strap_release: assert property (relSeq |-> ##[3:6] (txd1PinOe
        && armPinOe && strapPulldownOn == 4'h0)) else $error("no release");
    a_oe_pull_excl: assert property (macroPinOe |->
        strapPulldownOn == 4'h0) else $error("pulldown while driving");
    a_host_mode_kept: assert property (txd1PinOe && $past(txd1PinOe) |->
        $stable(hostMode) && $stable(clkoutFreqSel)) else $error("strap lost");
    a_pad_cfg_write: assert property (padCfgWrite |=>
        pullEnable == $past(pullEnableWr) && driveFull == $past(driveFullWr))
        else $error("pad config not taken");
    a_txen_active_low: assert property (!$past(sys_rst) |->
        txEnablePin1N == !$past(chanTxActive1)
        && txEnablePin2N == !$past(chanTxActive2)) else $error("tx enable");
    a_debug_route: assert property (!$past(sys_rst) |->
        debug_strobe_one == $past(debugSources[debugSelOne])
        && debug_strobe_two == $past(debugSources[debugSelTwo]))
        else $error("debug route");
    a_async_write: assert property (weRiseSeq |-> ##[2:4] coreWriteStrobe)
        else $error("write strobe missing");
endmodule

bind host_and_phy_pin_function_mux host_and_phy_pin_function_mux_sva
    host_and_phy_pin_function_mux_sva_inst (.*);

//--- dv/host_and_phy_pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
module host_and_phy_pin_function_mux_tb;
    import pin_mux_pkg::*;
    // ==================================================================
    // Signals
    logic clk = 1'b0, sys_rst = 1'b1, host_bus_clock_in = 1'b0;
    logic chipSelOrLowByteN = 1'b1, writeEnOrDirN = 1'b1;
    logic [DATA_W-1:0] hostDataIn = 16'h0, coreReadData = 16'h0;
    logic [DATA_W-1:0] hostDataOut, coreWriteData;
    logic hostDataOe, coreWriteStrobe, coreAccessByte, coreReadReq;
    host_mode_t hostMode;
    logic [1:0] clkoutFreqSel;
    logic guardTickPinIn, guardian_tick_out, guardTickPinOe, macroPinIn;
    logic guardian_macro_pulse_out, macroPinOe, armPinIn, armPinOut;
    logic armPinOe, txd1PinIn, txd1PinOut, txd1PinOe, txd2PinOut;
    logic [3:0] strapPulldownOn, pinIn;
    logic coreTick = 1'b0, coreMacro = 1'b0, coreArm = 1'b0;
    logic debugEnable = 1'b0, debug_strobe_one, debug_strobe_two;
    logic [DEBUG_SRC_W-1:0] debugSources = 8'h0;
    logic [DEBUG_SEL_W-1:0] debugSelOne = 3'h0, debugSelTwo = 3'h0;
    phy_type_t phy_type_select_field = PHY_XCVR;
    logic phyRxPin1 = 1'b1, phyRxPin2 = 1'b1, chanRx1, chanRx2;
    logic chanTxActive1 = 1'b0, chanTxActive2 = 1'b0;
    logic chanTxData1 = 1'b0, chanTxData2 = 1'b0;
    logic txEnablePin1N, txEnablePin2N, padCfgWrite = 1'b0;
    logic [INPUT_PINS-1:0] pullEnableWr = 24'h0, pullEnable;
    logic [OUTPUT_PINS-1:0] driveFullWr = 24'h0, driveFull;
    logic [2:0] rx1H = 3'h7, rx2H = 3'h7;
    logic [16:0] expQ[$];
    int mismatches = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    always #7.5 host_bus_clock_in = ~host_bus_clock_in;
    assign {txd1PinIn, armPinIn, macroPinIn, guardTickPinIn} = pinIn;
    host_and_phy_pin_function_mux host_and_phy_pin_function_mux_inst (.*);
    // Straps: memory-style host, arm pin pulled up gives clock select code 1.
    strap_board_model #(.PULL_UP(4'h4)) strap_board_model_inst (
        .padOut({txd1PinOut, armPinOut, guardian_macro_pulse_out,
            guardian_tick_out}),
        .padOe({txd1PinOe, armPinOe, macroPinOe, guardTickPinOe}),
        .padIn(pinIn)
    );
    // ==================================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Data is held four cycles past the rising strobe, beyond its sync.
    task automatic hostWrite(input logic [15:0] data, input logic byteN);
        hostDataIn = data;
        chipSelOrLowByteN = byteN;
        writeEnOrDirN = 1'b0;
        repeat (3) @(negedge clk);
        expQ.push_back({~byteN, data});
        writeEnOrDirN = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // ==================================================================
    // Result watcher and watchdog
    always @(negedge clk) begin
        if (coreWriteStrobe === 1'b1) begin
            if (expQ.size() == 0) chk("spare write", 32'h0, 32'h1);
            else chk("write", 32'(expQ.pop_front()),
                32'({coreAccessByte, coreWriteData}));
        end
    end
    initial begin
        #5000;
        mismatches++;
        end_sim;
    end
    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hF21E));
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        chk("pull reset", 32'(PULL_EN_RESET), 32'(pullEnable));
        chk("drive reset", 32'(DRIVE_FULL_RESET), 32'(driveFull));
        chk("strap pulls", 32'hF, 32'(strapPulldownOn));
        chk("txen idle", 32'h3, 32'({txEnablePin1N, txEnablePin2N}));
        for (int i = 0; i < 20 && txd1PinOe !== 1'b1; i++) @(negedge clk);
        chk("release", 32'h0, 32'({strapPulldownOn, ~txd1PinOe}));
        chk("host mode", 32'(HOST_ASYNC_MEM), 32'(hostMode));
        chk("external_clock_output sel", 32'h1, 32'(clkoutFreqSel));
        padCfgWrite = 1'b1;
        repeat (3) begin
            pullEnableWr = 24'($urandom);
            driveFullWr = 24'($urandom);
            @(negedge clk);
            chk("pull cfg", 32'(pullEnableWr), 32'(pullEnable));
            chk("drive cfg", 32'(driveFullWr), 32'(driveFull));
        end
        padCfgWrite = 1'b0;
        for (int p = 0; p < 2; p++) begin
            phy_type_select_field = p ? PHY_DIFF : PHY_XCVR;
            repeat (12) begin
                {chanTxActive1, chanTxActive2} = 2'($urandom);
                {chanTxData1, chanTxData2, phyRxPin1, phyRxPin2} = 4'($urandom);
                {coreTick, coreMacro, coreArm} = 3'($urandom);
                rx1H = {rx1H[1:0], phyRxPin1};
                rx2H = {rx2H[1:0], phyRxPin2};
                @(negedge clk);
                chk("txen", 32'({~chanTxActive1, ~chanTxActive2}),
                    32'({txEnablePin1N, txEnablePin2N}));
                chk("txd", 32'({p && !chanTxActive1 || chanTxData1,
                    p && !chanTxActive2 || chanTxData2}),
                    32'({txd1PinOut, txd2PinOut}));
                chk("rx", 32'({rx1H[2], rx2H[2]}), 32'({chanRx1, chanRx2}));
                chk("guardian", 32'({coreTick, coreMacro, coreArm}),
                    32'({guardian_tick_out, guardian_macro_pulse_out,
                    armPinOut}));
            end
        end
        debugEnable = 1'b1;
        for (int s = 0; s < 8; s++) begin
            debugSources = 8'($urandom);
            coreReadData = 16'($urandom);
            debugSelOne = 3'(s);
            debugSelTwo = 3'(7 - s);
            @(negedge clk);
            chk("debug", 32'({debugSources[s], debugSources[7 - s]}),
                32'({debug_strobe_one, debug_strobe_two}));
            chk("debug pins", 32'({debugSources[7 - s], debugSources[s]}),
                32'({guardian_tick_out, armPinOut}));
            chk("read data", 32'(coreReadData), 32'(hostDataOut));
            chk("read ctl", 32'h1, 32'({hostDataOe, coreReadReq}));
        end
        repeat (6) hostWrite(16'($urandom), 1'($urandom));
        repeat (8) @(negedge clk);
        chk("writes left", 32'h0, 32'(expQ.size()));
        end_sim;
    end
endmodule

//--- dv/strap_board_model.sv
// Board side of the four strap pins: pull resistors and wire level.
`timescale 1ns/1ps
// ==================================================================
// Board model
module strap_board_model #(
    parameter logic [3:0] PULL_UP = 4'h4
) (
    input wire logic [3:0] padOut,
    input wire logic [3:0] padOe,
    output logic [3:0] padIn
);
    // The board resistors outrank the weak internal pulldown.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : PULL_UP[i];
        end
    end
endmodule

//--- rtl/host_and_phy_pin_function_mux.sv
// Pin function multiplexer and reset-time strap latch.
`timescale 1ns/1ps

module host_and_phy_pin_function_mux (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_bus_clock_in,
    // Shared pins: chip-select or low-byte strobe, write or direction.
    input wire logic chipSelOrLowByteN,
    input wire logic writeEnOrDirN,
    input wire logic [pin_mux_pkg::DATA_W-1:0] hostDataIn,
    output logic [pin_mux_pkg::DATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    input wire logic [pin_mux_pkg::DATA_W-1:0] coreReadData,
    output logic [pin_mux_pkg::DATA_W-1:0] coreWriteData,
    output logic coreWriteStrobe,
    output logic coreAccessByte,
    output logic coreReadReq,
    output pin_mux_pkg::host_mode_t hostMode,
    output logic [1:0] clkoutFreqSel,
    // Strap pins as three signals each.
    input wire logic guardTickPinIn,
    output logic guardian_tick_out,
    output logic guardTickPinOe,
    input wire logic macroPinIn,
    output logic guardian_macro_pulse_out,
    output logic macroPinOe,
    input wire logic armPinIn,
    output logic armPinOut,
    output logic armPinOe,
    input wire logic txd1PinIn,
    output logic txd1PinOut,
    output logic txd1PinOe,
    output logic txd2PinOut,
    output logic [3:0] strapPulldownOn,
    // Core side signals.
    input wire logic coreTick,
    input wire logic coreMacro,
    input wire logic coreArm,
    input wire logic [pin_mux_pkg::DEBUG_SRC_W-1:0] debugSources,
    input wire logic [pin_mux_pkg::DEBUG_SEL_W-1:0] debugSelOne,
    input wire logic [pin_mux_pkg::DEBUG_SEL_W-1:0] debugSelTwo,
    input wire logic debugEnable,
    output logic debug_strobe_one,
    output logic debug_strobe_two,
    input wire pin_mux_pkg::phy_type_t phy_type_select_field,
    input wire logic phyRxPin1,
    input wire logic phyRxPin2,
    output logic chanRx1,
    output logic chanRx2,
    input wire logic chanTxActive1,
    input wire logic chanTxActive2,
    input wire logic chanTxData1,
    input wire logic chanTxData2,
    output logic txEnablePin1N,
    output logic txEnablePin2N,
    input wire logic [pin_mux_pkg::INPUT_PINS-1:0] pullEnableWr,
    input wire logic [pin_mux_pkg::OUTPUT_PINS-1:0] driveFullWr,
    input wire logic padCfgWrite,
    output logic [pin_mux_pkg::INPUT_PINS-1:0] pullEnable,
    output logic [pin_mux_pkg::OUTPUT_PINS-1:0] driveFull
);
    import pin_mux_pkg::*;

    // =====================================================================
    // Strap sequencer.
    strap_state_t state_q;
    logic [3:0] settle_q;
    logic [3:0] strapSync1_q;
    logic [3:0] strapSync2_q;
    logic [1:0] hostStrap_q;
    logic [1:0] clkStrap_q;
    logic released;

    always_ff @(posedge clk) begin
        strapSync1_q <= {txd1PinIn, armPinIn, macroPinIn, guardTickPinIn};
        strapSync2_q <= strapSync1_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_LATCH;
            settle_q <= 4'h0;
        end else begin
            unique case (state_q)
                ST_LATCH: begin
                    state_q <= ST_SETTLE;
                    settle_q <= 4'h0;
                end
                ST_SETTLE: begin
                    settle_q <= settle_q + 4'h1;
                    if (settle_q == SETTLE_CYCLES - 4'h1) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_LATCH;
            endcase
        end
    end

    // Straps are latched while the internal reset level holds, so the last
    // sample before release is the one kept.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hostStrap_q <= 2'h0;
            clkStrap_q <= 2'h0;
        end else if (state_q != ST_RUN) begin
            hostStrap_q <= {strapSync2_q[3], strapSync2_q[0]};
            clkStrap_q <= {strapSync2_q[1], strapSync2_q[2]};
        end
    end

    assign released = (state_q == ST_RUN);
    assign hostMode = host_mode_t'(hostStrap_q);
    assign clkoutFreqSel = clkStrap_q;
    // The board's pull resistors must dominate the weak pulldown.
    assign strapPulldownOn = released ? 4'h0 : 4'hF;

    // =====================================================================
    // Pad configuration.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullEnable <= PULL_EN_RESET;
            driveFull <= DRIVE_FULL_RESET;
        end else if (padCfgWrite) begin
            pullEnable <= pullEnableWr;
            driveFull <= driveFullWr;
        end
    end

    // =====================================================================
    // Guardian, debug and physical layer outputs.
    function automatic logic pick(input logic [DEBUG_SRC_W-1:0] src,
                                  input logic [DEBUG_SEL_W-1:0] sel);
        pick = src[sel];
    endfunction

    logic diffMode;
    assign diffMode = (phy_type_select_field == PHY_DIFF);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            guardian_tick_out <= 1'b0;
            guardian_macro_pulse_out <= 1'b0;
            armPinOut <= 1'b0;
            debug_strobe_one <= 1'b0;
            debug_strobe_two <= 1'b0;
        end else begin
            // Driven in every phy mode; unused by a differential driver.
            guardian_tick_out <= debugEnable ? pick(debugSources, debugSelTwo)
                                             : coreTick;
            guardian_macro_pulse_out <= coreMacro;
            armPinOut <= debugEnable ? pick(debugSources, debugSelOne)
                                     : coreArm;
            debug_strobe_one <= pick(debugSources, debugSelOne);
            debug_strobe_two <= pick(debugSources, debugSelTwo);
        end
    end

    assign guardTickPinOe = released;
    assign macroPinOe = released;
    assign armPinOe = released;
    assign txd1PinOe = released;

    logic [1:0] rxSync1_q;
    logic [1:0] rxSync2_q;
    always_ff @(posedge clk) begin
        rxSync1_q <= {phyRxPin2, phyRxPin1};
        rxSync2_q <= rxSync1_q;
    end

    // Both phy roles share the same pins per channel; the mode only changes
    // the idle levels so a differential driver never sees a false enable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanRx1 <= 1'b1;
            chanRx2 <= 1'b1;
            txd1PinOut <= 1'b1;
            txd2PinOut <= 1'b1;
            txEnablePin1N <= 1'b1;
            txEnablePin2N <= 1'b1;
        end else begin
            chanRx1 <= rxSync2_q[0];
            chanRx2 <= rxSync2_q[1];
            txd1PinOut <= (chanTxActive1 || !diffMode) ? chanTxData1
                                                        : 1'b1;
            txd2PinOut <= (chanTxActive2 || !diffMode) ? chanTxData2
                                                        : 1'b1;
            txEnablePin1N <= !chanTxActive1;
            txEnablePin2N <= !chanTxActive2;
        end
    end

    // =====================================================================
    // Host interface, on the host bus clock in multiplexed mode.
    logic [1:0] modeSync1_q;
    logic [1:0] modeSync2_q;
    logic hostRstSync1_q;
    logic hostRstSync2_q;
    always_ff @(posedge host_bus_clock_in) begin
        modeSync1_q <= hostStrap_q;
        modeSync2_q <= modeSync1_q;
        hostRstSync1_q <= !released;
        hostRstSync2_q <= hostRstSync1_q;
    end

    // The host clock is limited to 8 MHz, so one word per host edge is
    // always far slower than the core can take it.
    logic [DATA_W-1:0] muxData_q;
    logic muxByte_q;
    logic muxWrTgl_q;
    logic muxRead_q;
    always_ff @(posedge host_bus_clock_in) begin
        if (hostRstSync2_q) begin
            muxData_q <= 16'h0000;
            muxByte_q <= 1'b0;
            muxWrTgl_q <= 1'b0;
            muxRead_q <= 1'b0;
        end else if (modeSync2_q == HOST_MUXED) begin
            muxByte_q <= !chipSelOrLowByteN;
            muxRead_q <= writeEnOrDirN;
            if (!writeEnOrDirN) begin
                muxData_q <= hostDataIn;
                muxWrTgl_q <= !muxWrTgl_q;
            end
        end
    end

    logic [2:0] wrTglSync_q;
    logic [1:0] rdSync_q;
    logic [2:0] weSync_q;
    logic [1:0] ceSync_q;
    logic [DATA_W-1:0] amiData_q;
    logic [DATA_W-1:0] amiData2_q;
    always_ff @(posedge clk) begin
        wrTglSync_q <= {wrTglSync_q[1:0], muxWrTgl_q};
        rdSync_q <= {rdSync_q[0], muxRead_q};
        weSync_q <= {weSync_q[1:0], writeEnOrDirN};
        ceSync_q <= {ceSync_q[0], chipSelOrLowByteN};
        amiData_q <= hostDataIn;
        amiData2_q <= amiData_q;
    end

    logic amiMode;
    logic amiWrRise;
    logic muxWrEvent;
    assign amiMode = (hostMode == HOST_ASYNC_MEM);
    // Data is taken when the write strobe ends, while still valid. The edge
    // is found behind the second flop so no metastable value is decoded.
    assign amiWrRise = weSync_q[1] && !weSync_q[2];
    assign muxWrEvent = wrTglSync_q[2] ^ wrTglSync_q[1];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coreWriteData <= 16'h0000;
            coreWriteStrobe <= 1'b0;
            coreAccessByte <= 1'b0;
            coreReadReq <= 1'b0;
            hostDataOut <= 16'h0000;
            hostDataOe <= 1'b0;
        end else begin
            coreWriteStrobe <= 1'b0;
            hostDataOut <= coreReadData;
            if (!released) begin
                hostDataOe <= 1'b0;
                coreReadReq <= 1'b0;
            end else if (amiMode) begin
                coreAccessByte <= !ceSync_q[1];
                coreReadReq <= weSync_q[1];
                hostDataOe <= 1'b0;
                if (amiWrRise) begin
                    coreWriteData <= amiData2_q;
                    coreWriteStrobe <= 1'b1;
                end
            end else if (hostMode == HOST_MUXED) begin
                coreAccessByte <= muxByte_q;
                coreReadReq <= rdSync_q[1];
                hostDataOe <= rdSync_q[1];
                if (muxWrEvent) begin
                    coreWriteData <= muxData_q;
                    coreWriteStrobe <= 1'b1;
                end
            end else begin
                hostDataOe <= 1'b0;
                coreReadReq <= 1'b0;
            end
        end
    end

endmodule

//--- rtl/pin_mux_pkg.sv
// Constants shared by the host and physical layer pin function multiplexer.
package pin_mux_pkg;

    // =====================================================================
    // Host interface selection, taken from the two latched straps.
    typedef enum logic [1:0] {
        HOST_ASYNC_MEM = 2'h0,
        HOST_MUXED = 2'h1,
        HOST_RSVD_A = 2'h2,
        HOST_RSVD_B = 2'h3
    } host_mode_t;

    // =====================================================================
    // Physical layer selection field of module configuration register zero.
    typedef enum logic [1:0] {
        PHY_XCVR = 2'h0,
        PHY_DIFF = 2'h1,
        PHY_RSVD_A = 2'h2,
        PHY_RSVD_B = 2'h3
    } phy_type_t;

    // =====================================================================
    // Host access kinds decoded from the shared strobes.
    typedef enum logic [1:0] {
        ACC_WORD = 2'h0,
        ACC_BYTE = 2'h1
    } acc_size_t;

    // =====================================================================
    // Strap sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_LATCH = 3'h1,
        ST_SETTLE = 3'h2,
        ST_RUN = 3'h4
    } strap_state_t;

    localparam int DATA_W = 16;
    localparam int INPUT_PINS = 24;
    localparam int OUTPUT_PINS = 24;
    localparam int DEBUG_SEL_W = 3;
    localparam int DEBUG_SRC_W = 8;

    // Reset values: pulls off, full drive strength on every output.
    localparam logic [INPUT_PINS-1:0] PULL_EN_RESET = 24'h000000;
    localparam logic [OUTPUT_PINS-1:0] DRIVE_FULL_RESET = 24'hFFFFFF;

    // Pin indices of the four strap pins within the pull/drive vectors.
    localparam int PIN_TICK = 0;
    localparam int PIN_MACRO = 1;
    localparam int PIN_ARM = 2;
    localparam int PIN_TXD1 = 3;

    // Host clock limit, core clock, and cycles spent in ST_SETTLE before release.
    localparam int MAX_HOST_CLK_MHZ = 8;
    localparam int CLK_MHZ = 100;
    localparam logic [3:0] SETTLE_CYCLES = 4'h4;

endpackage
